// ===== hdl/pmc_pkg.sv
// package for the performance monitor control block
package pmc_pkg;
   // coprocessor register selection
   localparam logic [2:0] PMC_OP1_ACCESS    = 3'h0;
   localparam logic [3:0] PMC_CRN_ACCESS    = 4'hF;
   localparam logic [3:0] PMC_CRM_ACCESS    = 4'h9;
   localparam logic [2:0] PMC_OP2_ACCESS    = 3'h0;
   localparam logic [2:0] PMC_OP1_CONTROL   = 3'h0;
   localparam logic [3:0] PMC_CRN_CONTROL   = 4'hF;
   localparam logic [3:0] PMC_CRM_CONTROL   = 4'hC;
   localparam logic [2:0] PMC_OP2_CONTROL   = 3'h0;
   // control register fields
   localparam int PMC_SEL0_LSB   = 20;
   localparam int PMC_SEL1_LSB   = 12;
   localparam int PMC_EXPORT_BIT = 11;
   localparam int PMC_OVF_LSB    = 8;
   localparam int PMC_IRQEN_LSB  = 4;
   localparam int PMC_DIV_BIT    = 3;
   localparam int PMC_CCLR_BIT   = 2;
   localparam int PMC_ECLR_BIT   = 1;
   localparam int PMC_EN_BIT     = 0;
   localparam logic [31:0] PMC_CTRL_MASK   = 32'h0FFF_FF79;
   localparam logic [31:0] PMC_ACCESS_MASK = 32'h0000_0001;
   localparam logic [31:0] PMC_CTRL_RESET   = 32'h0000_0000;
   localparam logic [31:0] PMC_ACCESS_RESET = 32'h0000_0000;
   localparam logic [7:0]  PMC_EVT_EVERY_CYCLE = 8'hFF;
   localparam logic [5:0]  PMC_DIV_LAST = 6'h3F;
   localparam int PMC_EVENTS = 256;
   localparam int PMC_BUS_W  = 20;

   typedef struct packed {
      logic        valid;
      logic        write;
      logic        secure;
      logic        privileged;
      logic [2:0]  op1;
      logic [3:0]  crn;
      logic [3:0]  crm;
      logic [2:0]  op2;
      logic [31:0] wdata;
   } pmc_xfer_t;

   typedef struct packed {
      logic        done;
      logic        undefined;
      logic [31:0] rdata;
   } pmc_reply_t;
endpackage : pmc_pkg

// ===== hdl/pmc_top.sv
// performance monitor control register and counters
`timescale 1ns/1ns
`default_nettype none
// Function
// RL1 - access bit resets 0; 0 limits access, 1 opens monitor and validation registers
// RL2 - access register only secure privileged; others raise undefined
// RL3 - write lock high makes secure access register write undefined
// RL4 - access register selected by op1 0, c15, c9, op2 0
// RL5 - control register shared by both worlds, user and privileged access
// RL6 - bits 27:20 select counter 0 event, reset zero
// RL7 - bits 19:12 select counter 1 event, reset zero
// RL8 - bit 11 exports live events, else event bus zero
// RL9 - bits 10:8 overflow flags, write one clears
// RL10 - bits 6:4 enable interrupt reporting per counter
// RL11 - bit 3 divides cycle counter by 64
// RL12 - writing one to bit 2 clears cycle counter
// RL13 - writing one to bit 1 clears both event counters
// RL14 - bit 0 enables all three counters
// RL15 - event code FF counts every cycle
// RL16 - overflow flag sets when an enabled counter wraps to zero
// RL17 - interrupt while any enabled overflow flag is set
// RL18 - reserved bits read zero and ignore writes
module pmc_top
   import pmc_pkg::*;
(
   input  wire logic                  clock,
   input  wire logic                  reset_n,
   input  wire pmc_xfer_t             xfer,
   input  wire logic                  secure_config_write_lock,
   input  wire logic [PMC_EVENTS-1:0] event_in,
   input  wire logic [PMC_BUS_W-1:0]  event_bus_in,
   output var  pmc_reply_t            reply,
   output var  logic [PMC_BUS_W-1:0]  event_export_bus,
   output var  logic                  user_access_open,
   output var  logic                  irq,
   output var  logic [31:0]           cycle_count,
   output var  logic [31:0]           counter0_count,
   output var  logic [31:0]           counter1_count
);

   // true when a valid transfer names the given coprocessor register
   function automatic logic hits(input pmc_xfer_t x, input logic [2:0] o1, input logic [3:0] n,
                                 input logic [3:0] m, input logic [2:0] o2);
      logic match;
      match = x.op1 == o1;
      match = match && x.crn == n;
      match = match && x.crm == m;
      match = match && x.op2 == o2;
      hits  = x.valid && match;
   endfunction

   // code FF stands for every cycle, others pick one event line
   function automatic logic pick_event(input logic [7:0] code, input logic [PMC_EVENTS-1:0] lines);
      if (code == PMC_EVT_EVERY_CYCLE) begin
         pick_event = 1'b1; // RL15
      end else begin
         pick_event = lines[code];
      end
   endfunction

   ////////////////////////////////////////////////////////////////////////
   // registers
   logic [31:0] ctrl_reg;
   logic [31:0] ctrl_next;
   logic        access_reg;
   logic        access_next;
   logic [5:0]  div_reg;
   logic [31:0] cyc_reg;
   logic [31:0] cnt_reg [2];
   logic [31:0] cnt_next [2];
   logic [1:0]  cnt_wrap;
   logic        lock_s1_reg;
   logic        lock_s2_reg;
   logic        lock_s3_reg;
   logic        lock_reg;
   logic        lock_next;
   logic [5:0]  div_next;
   logic [31:0] cyc_next;
   pmc_reply_t  reply_next;
   logic [PMC_BUS_W-1:0] export_next;
   logic        open_next;
   logic        irq_next;

   ////////////////////////////////////////////////////////////////////////
   // write lock synchroniser
   // lock pin comes from outside, a change counts once stages two and three agree
   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         lock_s1_reg <= 1'b0;
         lock_s2_reg <= 1'b0;
         lock_s3_reg <= 1'b0;
      end else begin
         lock_s1_reg <= secure_config_write_lock;
         lock_s2_reg <= lock_s1_reg;
         lock_s3_reg <= lock_s2_reg;
      end
   end

   assign lock_next = (lock_s2_reg == lock_s3_reg) ? lock_s3_reg : lock_reg; // RL3

   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         lock_reg <= 1'b0;
      end else begin
         lock_reg <= lock_next;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // decode
   wire sel_access  = hits(xfer, PMC_OP1_ACCESS, PMC_CRN_ACCESS, PMC_CRM_ACCESS, PMC_OP2_ACCESS); // RL4
   wire sel_control = hits(xfer, PMC_OP1_CONTROL, PMC_CRN_CONTROL, PMC_CRM_CONTROL, PMC_OP2_CONTROL);
   wire access_ok   = xfer.secure && xfer.privileged; // RL2
   wire access_undef = sel_access && (!access_ok || (xfer.write && lock_reg)); // RL2 RL3
   wire control_ok  = xfer.privileged || access_reg; // RL1 RL5
   wire control_undef = sel_control && !control_ok; // RL1
   wire access_wr   = sel_access && xfer.write && !access_undef;
   wire control_wr  = sel_control && xfer.write && !control_undef;

   wire enable      = ctrl_reg[PMC_EN_BIT]; // RL14
   wire divide      = ctrl_reg[PMC_DIV_BIT];
   wire [7:0] sel0  = ctrl_reg[PMC_SEL0_LSB +: 8]; // RL6
   wire [7:0] sel1  = ctrl_reg[PMC_SEL1_LSB +: 8]; // RL7

   ////////////////////////////////////////////////////////////////////////
   // field views
   wire cycle_overflow_flag    = ctrl_reg[PMC_OVF_LSB + 2]; // RL9
   wire counter1_overflow_flag = ctrl_reg[PMC_OVF_LSB + 1]; // RL9
   wire counter0_overflow_flag = ctrl_reg[PMC_OVF_LSB]; // RL9
   wire cycle_irq_enable       = ctrl_reg[PMC_IRQEN_LSB + 2]; // RL10
   wire counter1_irq_enable    = ctrl_reg[PMC_IRQEN_LSB + 1]; // RL10
   wire counter0_irq_enable    = ctrl_reg[PMC_IRQEN_LSB]; // RL10
   wire export_on              = ctrl_reg[PMC_EXPORT_BIT]; // RL8

   wire cyc_tick    = enable && (!divide || div_reg == PMC_DIV_LAST); // RL11
   wire cyc_wrap    = cyc_tick && cyc_reg == 32'hFFFF_FFFF;
   wire cyc_clear   = control_wr && xfer.wdata[PMC_CCLR_BIT]; // RL12
   wire evt_clear   = control_wr && xfer.wdata[PMC_ECLR_BIT]; // RL13
   wire [2:0] ovf_set = {cyc_wrap, cnt_wrap}; // RL16
   wire [2:0] ovf_clr = control_wr ? xfer.wdata[PMC_OVF_LSB +: 3] : 3'h0; // RL9

   // event selection
   wire ev0 = pick_event(sel0, event_in); // RL6 RL15
   wire ev1 = pick_event(sel1, event_in); // RL7 RL15
   wire [1:0] ev = {ev1, ev0};

   ////////////////////////////////////////////////////////////////////////
   // event counters
   // a clear wins over a count in the same cycle
   genvar gi;
   generate
      for (gi = 0; gi < 2; gi++) begin : g_cnt
         assign cnt_wrap[gi] = enable && ev[gi] && cnt_reg[gi] == 32'hFFFF_FFFF; // RL16
         assign cnt_next[gi] = evt_clear ? 32'h0000_0000 : // RL13
                               (enable && ev[gi]) ? cnt_reg[gi] + 32'h0000_0001 : cnt_reg[gi]; // RL14
         always_ff @(posedge clock or negedge reset_n) begin
            if (!reset_n) begin
               cnt_reg[gi] <= 32'h0000_0000;
            end else begin
               cnt_reg[gi] <= cnt_next[gi];
            end
         end
      end
   endgenerate

   ////////////////////////////////////////////////////////////////////////
   // register updates
   always_comb begin
      ctrl_next = ctrl_reg;
      if (control_wr) begin
         ctrl_next[PMC_SEL0_LSB +: 8]  = xfer.wdata[PMC_SEL0_LSB +: 8]; // RL6
         ctrl_next[PMC_SEL1_LSB +: 8]  = xfer.wdata[PMC_SEL1_LSB +: 8]; // RL7
         ctrl_next[PMC_EXPORT_BIT]     = xfer.wdata[PMC_EXPORT_BIT]; // RL8
         ctrl_next[PMC_OVF_LSB +: 3]   = ctrl_reg[PMC_OVF_LSB +: 3] & ~ovf_clr; // RL9
         ctrl_next[PMC_IRQEN_LSB +: 3] = xfer.wdata[PMC_IRQEN_LSB +: 3]; // RL10
         ctrl_next[PMC_DIV_BIT]        = xfer.wdata[PMC_DIV_BIT]; // RL11
         ctrl_next[PMC_EN_BIT]         = xfer.wdata[PMC_EN_BIT]; // RL14
      end
      // a wrap in the same cycle as its clear wins
      ctrl_next[PMC_OVF_LSB +: 3] = ctrl_next[PMC_OVF_LSB +: 3] | ovf_set; // RL16
      // strobe bits and reserved bits never hold a value
      ctrl_next = ctrl_next & PMC_CTRL_MASK; // RL18
   end

   always_comb begin
      access_next = access_reg;
      if (access_wr) begin
         access_next = xfer.wdata[0]; // RL1
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // read side
   wire [31:0] rd_ctrl   = ctrl_reg & PMC_CTRL_MASK; // RL18
   wire [31:0] rd_access = {31'h0000_0000, access_reg} & PMC_ACCESS_MASK; // RL18
   wire [31:0] rd_data   = sel_access ? rd_access : rd_ctrl;
   wire [2:0]  irq_src   = {cycle_overflow_flag & cycle_irq_enable, // RL10 RL17
                            counter1_overflow_flag & counter1_irq_enable,
                            counter0_overflow_flag & counter0_irq_enable};

   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         ctrl_reg <= PMC_CTRL_RESET;
      end else begin
         ctrl_reg <= ctrl_next;
      end
   end

   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         access_reg <= PMC_ACCESS_RESET[0]; // RL1
      end else begin
         access_reg <= access_next;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // cycle counter
   // prescaler only advances while counting is enabled
   assign div_next = enable ? div_reg + 6'h01 : div_reg; // RL11
   assign cyc_next = cyc_clear ? 32'h0000_0000 : // RL12
                     cyc_tick ? cyc_reg + 32'h0000_0001 : cyc_reg; // RL14

   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         div_reg <= 6'h00;
      end else begin
         div_reg <= div_next;
      end
   end

   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         cyc_reg <= 32'h0000_0000;
      end else begin
         cyc_reg <= cyc_next;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // outputs
   wire xfer_undef = access_undef || control_undef; // RL2 RL3
   // refused reads and all writes answer with zero data
   wire [31:0] reply_data = (!xfer.write && !xfer_undef) ? rd_data : 32'h0000_0000;
   assign reply_next  = '{done: sel_access || sel_control, undefined: xfer_undef, rdata: reply_data};
   assign export_next = export_on ? event_bus_in : '0; // RL8
   assign open_next   = access_reg; // RL1
   assign irq_next    = |irq_src; // RL17

   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         reply <= '0;
      end else begin
         reply <= reply_next;
      end
   end

   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         event_export_bus <= '0;
      end else begin
         event_export_bus <= export_next;
      end
   end

   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         user_access_open <= 1'b0;
      end else begin
         user_access_open <= open_next;
      end
   end

   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         irq <= 1'b0;
      end else begin
         irq <= irq_next;
      end
   end

   assign cycle_count    = cyc_reg;
   assign counter0_count = cnt_reg[0];
   assign counter1_count = cnt_reg[1];

endmodule // pmc_top
`default_nettype wire

// ===== dv/pmc_top_checker.sv
// port assertions for the monitor control block
`timescale 1ns/1ns
`default_nettype none
module pmc_top_checker
   import pmc_pkg::*;
(
   input wire logic                 clock,
   input wire logic                 reset_n,
   input wire pmc_xfer_t            xfer,
   input wire logic                 secure_config_write_lock,
   input wire logic [PMC_BUS_W-1:0] event_bus_in,
   input wire pmc_reply_t           reply,
   input wire logic [PMC_BUS_W-1:0] event_export_bus,
   input wire logic                 user_access_open,
   input wire logic [31:0]          cycle_count,
   input wire logic [31:0]          counter0_count
);
   default clocking @(posedge clock); endclocking
   default disable iff (!reset_n);
   wire base = xfer.op1 == PMC_OP1_ACCESS && xfer.crn == PMC_CRN_ACCESS && xfer.op2 == PMC_OP2_ACCESS;
   wire acc  = base && xfer.crm == PMC_CRM_ACCESS;
   wire ctl  = base && xfer.crm == PMC_CRM_CONTROL;
   sequence s_acc; xfer.valid && acc; endsequence
   sequence s_lock; secure_config_write_lock [*5]; endsequence
   property p_done; xfer.valid && (acc || ctl) |=> reply.done; endproperty
   a_done: assert property (p_done) else $error("decoded access got no reply");
   property p_miss; xfer.valid && !acc && !ctl |=> !reply.done; endproperty
   a_miss: assert property (p_miss) else $error("foreign encoding got a reply");
   property p_nsec; s_acc ##0 !(xfer.secure && xfer.privileged) |=> reply.undefined; endproperty
   a_nsec: assert property (p_nsec) else $error("access register open to lesser mode");
   property p_lock; s_lock ##0 s_acc ##0 xfer.write |=> reply.undefined; endproperty
   a_lock: assert property (p_lock) else $error("locked write not refused");
   property p_udat; reply.undefined |-> reply.done && reply.rdata == 32'h0; endproperty
   a_udat: assert property (p_udat) else $error("refused reply carries data");
   property p_open; $rose(user_access_open) |-> $past(reply.done && !reply.undefined); endproperty
   a_open: assert property (p_open) else $error("access bit rose without write");
   property p_exp; event_export_bus != '0 |-> event_export_bus == $past(event_bus_in); endproperty
   a_exp: assert property (p_exp) else $error("export bus not live events");
   property p_cyc; $changed(cycle_count) |-> cycle_count == $past(cycle_count) + 32'h1 || cycle_count == 32'h0;
   endproperty
   a_cyc: assert property (p_cyc) else $error("cycle count jumped");
   property p_cnt0; $changed(counter0_count) |-> counter0_count == $past(counter0_count) + 32'h1 ||
      counter0_count == 32'h0; endproperty
   a_cnt0: assert property (p_cnt0) else $error("counter 0 jumped");
endmodule // pmc_top_checker
bind pmc_top pmc_top_checker chk (.clock, .reset_n, .xfer, .secure_config_write_lock, .event_bus_in, .reply,
   .event_export_bus, .user_access_open, .cycle_count, .counter0_count);
`default_nettype wire

// ===== dv/pmc_core_model.sv
// core model issuing coprocessor transfers
`timescale 1ns/1ns
`default_nettype none
module pmc_core_model
   import pmc_pkg::*;
(
   input  wire logic       clock,
   input  wire pmc_reply_t reply,
   output var  pmc_xfer_t  xfer
);
   initial xfer = '0;
   task automatic op(input logic w, s, p, input logic [3:0] m, input logic [31:0] d, output pmc_reply_t r);
      @(posedge clock);
      xfer <= '{1'b1, w, s, p, PMC_OP1_ACCESS, PMC_CRN_ACCESS, m, PMC_OP2_ACCESS, d};
      @(posedge clock);
      // valid and write clear and the other released fields flip so stale values never look valid
      xfer <= {1'b0, ~xfer[47:0]};
      #1 r = reply;
   endtask
endmodule // pmc_core_model
`default_nettype wire

// ===== dv/pmc_top_test.sv
// self-checking bench for the monitor control block
`timescale 1ns/1ns
`default_nettype none
module pmc_top_test import pmc_pkg::*;;
   localparam logic [3:0] C = PMC_CRM_CONTROL, A = PMC_CRM_ACCESS;
   logic clock = 0, reset_n = 0, lock = 0, open, irq;
   logic [PMC_EVENTS-1:0] event_in = '0;
   logic [PMC_BUS_W-1:0]  bus_in = '0, bus_out;
   pmc_xfer_t  xfer;
   pmc_reply_t reply, r;
   logic [31:0] cyc, c0, c1, a, v;
   int num_errors = 0, cmp_count = 0, ticks = 0;
   pmc_core_model core (.clock, .reply, .xfer);
   pmc_top uut (.clock, .reset_n, .xfer, .secure_config_write_lock(lock), .event_in, .event_bus_in(bus_in),
      .reply, .event_export_bus(bus_out), .user_access_open(open), .irq, .cycle_count(cyc),
      .counter0_count(c0), .counter1_count(c1));
   initial begin
      forever #25 clock = ~clock;
   end
   task automatic check(string n, logic [31:0] e, logic [31:0] g);
      cmp_count++;
      if (e !== g) begin
         num_errors++;
         $display("BAD %s expected %h seen %h", n, e, g);
      end
   endtask
   task automatic complete_run();
      if (num_errors == 0 && cmp_count > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask
   function automatic logic [31:0] ctrl_back(logic [31:0] d);
      return d & PMC_CTRL_MASK & ~32'h700;
   endfunction
   always @(posedge clock) begin
      event_in <= {8{$urandom}};
      ticks <= ticks + 1;
      if (ticks == 3000) begin
         num_errors++;
         complete_run();
      end
   end
   initial begin
      void'($urandom(54963));
      repeat (8) @(posedge clock);
      reset_n <= 1'b1;
      core.op(0, 1, 1, C, 0, r);
      check("ctrl reset", PMC_CTRL_RESET, r.rdata);
      core.op(0, 0, 0, C, 0, r);
      check("user ctrl refused", 1, 32'(r.undefined));
      for (int k = 0; k < 3; k++) begin
         core.op(k[0], k[0], k[1], A, 1, r);
         check("access refused", 1, 32'(r.undefined));
      end
      @(posedge clock) lock <= 1'b1;
      repeat (4) @(posedge clock);
      core.op(1, 1, 1, A, 1, r);
      check("locked write", 1, 32'(r.undefined));
      @(posedge clock) lock <= 1'b0;
      repeat (4) @(posedge clock);
      core.op(1, 1, 1, A, $urandom | 1, r);
      core.op(0, 1, 1, A, 0, r);
      check("access read", 1, r.rdata);
      check("open", 1, 32'(open));
      repeat (4) begin
         v = $urandom & ~32'h1;
         core.op(1, 0, 0, C, v, r);
         core.op(0, 0, 0, C, 0, r);
         check("ctrl read", ctrl_back(v), r.rdata);
      end
      core.op(1, 0, 1, C, 32'h0FF0_0007, r);
      a = cyc;
      v = c0;
      repeat (10) @(posedge clock);
      #1 check("cycle step", 10, cyc - a);
      check("every cycle event", 10, c0 - v);
      core.op(1, 1, 1, C, 32'h0000_000D, r);
      check("cycle clear", 0, cyc);
      a = cyc;
      repeat (128) @(posedge clock);
      #1 check("divided count", 2, cyc - a);
      core.op(1, 1, 1, C, 32'h0000_0002, r);
      check("event clear", 0, c0);
      repeat (5) @(posedge clock);
      #1 check("disabled hold", 0, c0);
      @(posedge clock) bus_in <= PMC_BUS_W'($urandom);
      core.op(1, 1, 1, C, 32'h0000_0800, r);
      repeat (2) @(posedge clock);
      #1 check("export on", 32'(bus_in), 32'(bus_out));
      core.op(1, 1, 1, C, 0, r);
      repeat (2) @(posedge clock);
      #1 check("export off", 0, 32'(bus_out));
      check("no overflow irq", 0, 32'(irq));
      complete_run();
   end
endmodule // pmc_top_test
`default_nettype wire
